// >>> logic/wst_pkg.sv
// Constants, carrier types and state layout of the windowed supervisor timer.
// Assumes one system clock and a synchronous, active-high reset.
// Function
// - A time-out before a reload within the period resets the chip if rst_mode is set, else raises an interrupt.
// - With windowing, a reload counts only between the window and time-out.
// - A warning interrupt may be raised at a set count before time-out.
// - Software can enable but never disable; only reset or an event clears it.
// - A wrong feed sequence acts like a time-out, reset or interrupt.
// - A readable flag records that the last reset came from this timer.
// - Timing is a 24-bit counter behind a prescaler on the supervisor clock.
// - The prescaler divides by 4 and the period spans 256 to 2^24 ticks.
// - The counter is clocked by the system clock and steps on prescaled supervisor clock edges.
// - The interrupt can raise a wake request when wake and irq are enabled.
package wst_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 24;
  localparam int PRE_W  = 2;

  localparam logic [ADDR_W-1:0] OFS_MODE    = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_FEED    = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_WARN    = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_WINDOW  = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h18;

  // Mode register bit positions
  localparam int MODE_EN      = 0;
  localparam int MODE_RSTMODE = 1;
  localparam int MODE_TMO     = 2;
  localparam int MODE_WARN    = 3;
  localparam int MODE_WARN_IE = 4;
  localparam int MODE_WAKE_EN = 5;
  // Status register bit positions
  localparam int STAT_WDRST   = 0;
  localparam int STAT_ARMED   = 1;

  localparam logic [7:0] KEY_FIRST  = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;

  localparam logic [CNT_W-1:0] TC_MIN       = 24'h0000FF;
  localparam logic [CNT_W-1:0] TC_RESET     = 24'hFFFFFF;
  localparam logic [CNT_W-1:0] WARN_RESET   = 24'h000000;
  localparam logic [CNT_W-1:0] WINDOW_RESET = 24'hFFFFFF;
  localparam logic [PRE_W-1:0] PRE_LAST     = 2'h3;
  localparam logic [PRE_W-1:0] PRE_STEP     = 2'h1;

  typedef enum logic [0:0] {
    FEED_IDLE  = 1'b0,
    FEED_ARMED = 1'b1
  } wst_feed_type;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } wst_av_req_type;

  typedef struct packed {
    logic [2:0]        sync;
    logic [PRE_W-1:0]  pre;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  tc;
    logic [CNT_W-1:0]  warn_val;
    logic [CNT_W-1:0]  window;
    logic              en;
    logic              rst_mode;
    logic              warn_ie;
    logic              wake_en;
    logic              tmo;
    logic              warn;
    logic              wdrst;
    logic              pend;
    wst_feed_type      feed;
    logic              ack;
    logic [DATA_W-1:0] rdata;
    logic              chip_reset;
    logic              irq;
    logic              wake;
  } wst_state_type;

  localparam wst_state_type ST_RESET = '{
    sync: 3'h0, pre: 2'h0, cnt: TC_RESET, tc: TC_RESET,
    warn_val: WARN_RESET, window: WINDOW_RESET, en: 1'b0,
    rst_mode: 1'b0, warn_ie: 1'b0, wake_en: 1'b0, tmo: 1'b0,
    warn: 1'b0, wdrst: 1'b0, pend: 1'b0, feed: FEED_IDLE, ack: 1'b0,
    rdata: 32'h0, chip_reset: 1'b0, irq: 1'b0, wake: 1'b0};
endpackage

// >>> logic/wst_windowed_supervisor_timer.sv
// Windowed supervisor timer with an Avalon-MM register slave.
// Assumes supervisor_clock is far slower than clk and por_rst comes
// only with sys_rst at power-up.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
module wst_windowed_supervisor_timer (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    por_rst,
  input  wire logic                    supervisor_clock,
  input  wst_pkg::wst_av_req_type      av_req,
  output logic [wst_pkg::DATA_W-1:0]   av_readdata,
  output logic                         av_waitrequest,
  output logic                         chip_reset,
  output logic                         irq,
  output logic                         wake_req
);
  import wst_pkg::*;

  wst_state_type r;
  wst_state_type next_r;
  logic          rise;
  logic          tick;
  logic          access;
  logic          wr;
  logic          feed_wr;
  logic          good_feed;
  logic          bad_feed;
  logic          window_bad;
  logic          expire;
  logic          event_hit;

  always_comb begin
    next_r = r;
    next_r.sync = {r.sync[1:0], supervisor_clock};
    // Edge seen between second and third stage only
    rise = r.sync[1] & ~r.sync[2];
    tick = rise && (r.pre == PRE_LAST);
    if (rise) begin
      next_r.pre = r.pre + PRE_STEP;
    end
    access = (av_req.read | av_req.write) & r.ack;
    wr = av_req.write & r.ack;
    feed_wr = wr && (av_req.address == OFS_FEED);
    next_r.ack = (av_req.read | av_req.write) & ~r.ack;
    good_feed = 1'b0;
    bad_feed = 1'b0;
    if (access) begin
      case (r.feed)
        FEED_IDLE: begin
          if (feed_wr) begin
            if (av_req.writedata[7:0] == KEY_FIRST) begin
              next_r.feed = FEED_ARMED;
            end else begin
              bad_feed = 1'b1;
            end
          end
        end
        FEED_ARMED: begin
          next_r.feed = FEED_IDLE;
          if (feed_wr && av_req.writedata[7:0] == KEY_SECOND) begin
            good_feed = 1'b1;
          end else begin
            bad_feed = 1'b1;
          end
        end
        default: next_r.feed = FEED_IDLE;
      endcase
    end
    window_bad = good_feed && r.en && (r.cnt > r.window);
    if (good_feed && !window_bad) begin
      next_r.pend = 1'b1;
    end
    if (wr) begin
      if (av_req.address == OFS_MODE) begin
        if (av_req.writedata[MODE_EN]) begin
          next_r.en = 1'b1;
        end
        next_r.rst_mode = av_req.writedata[MODE_RSTMODE];
        next_r.warn_ie = av_req.writedata[MODE_WARN_IE];
        next_r.wake_en = av_req.writedata[MODE_WAKE_EN];
        if (av_req.writedata[MODE_TMO]) begin
          next_r.tmo = 1'b0;
        end
        if (av_req.writedata[MODE_WARN]) begin
          next_r.warn = 1'b0;
        end
      end else if (av_req.address == OFS_TIMEOUT) begin
        if (av_req.writedata[CNT_W-1:0] < TC_MIN) begin
          next_r.tc = TC_MIN;
        end else begin
          next_r.tc = av_req.writedata[CNT_W-1:0];
        end
      end else if (av_req.address == OFS_WARN) begin
        next_r.warn_val = av_req.writedata[CNT_W-1:0];
      end else if (av_req.address == OFS_WINDOW) begin
        next_r.window = av_req.writedata[CNT_W-1:0];
      end else if (av_req.address == OFS_STATUS) begin
        if (av_req.writedata[STAT_WDRST]) begin
          next_r.wdrst = 1'b0;
        end
      end
    end
    expire = 1'b0;
    if (tick) begin
      if (r.pend) begin
        next_r.cnt = r.tc;
        next_r.pend = 1'b0;
      end else if (r.en) begin
        if (r.cnt == '0) begin
          expire = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 24'h000001;
        end
        if (r.cnt == r.warn_val) begin
          next_r.warn = 1'b1;
        end
      end
    end
    event_hit = r.en & (expire | bad_feed | window_bad);
    next_r.chip_reset = event_hit & r.rst_mode;
    if (event_hit) begin
      next_r.en = 1'b0;
      next_r.cnt = r.tc;
      next_r.pend = 1'b0;
      if (r.rst_mode) begin
        next_r.wdrst = 1'b1;
      end else begin
        next_r.tmo = 1'b1;
      end
    end
    next_r.irq = next_r.tmo | (next_r.warn & next_r.warn_ie);
    next_r.wake = next_r.irq & next_r.wake_en;
    if ((av_req.read | av_req.write) & ~r.ack) begin
      next_r.rdata = '0;
      if (av_req.address == OFS_MODE) begin
        next_r.rdata[MODE_EN] = r.en;
        next_r.rdata[MODE_RSTMODE] = r.rst_mode;
        next_r.rdata[MODE_TMO] = r.tmo;
        next_r.rdata[MODE_WARN] = r.warn;
        next_r.rdata[MODE_WARN_IE] = r.warn_ie;
        next_r.rdata[MODE_WAKE_EN] = r.wake_en;
      end else if (av_req.address == OFS_TIMEOUT) begin
        next_r.rdata[CNT_W-1:0] = r.tc;
      end else if (av_req.address == OFS_COUNT) begin
        next_r.rdata[CNT_W-1:0] = r.cnt;
      end else if (av_req.address == OFS_WARN) begin
        next_r.rdata[CNT_W-1:0] = r.warn_val;
      end else if (av_req.address == OFS_WINDOW) begin
        next_r.rdata[CNT_W-1:0] = r.window;
      end else if (av_req.address == OFS_STATUS) begin
        next_r.rdata[STAT_WDRST] = r.wdrst;
        next_r.rdata[STAT_ARMED] = (r.feed == FEED_ARMED);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= ST_RESET;
      // Synchroniser keeps tracking pin, no false edge at release
      r.sync <= next_r.sync;
      // Flag survives all but power-on reset
      r.wdrst <= r.wdrst & ~por_rst;
    end else begin
      r <= next_r;
    end
  end

  assign av_readdata    = r.rdata;
  assign av_waitrequest = ~r.ack;
  assign chip_reset     = r.chip_reset;
  assign irq            = r.irq;
  assign wake_req       = r.wake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_request;
    (av_req.read | av_req.write) && !r.ack;
  endsequence

  sequence s_key_fault;
    r.en && access && r.feed == FEED_IDLE && feed_wr
      && av_req.writedata[7:0] != KEY_FIRST;
  endsequence

  a_enable_sticky: assert property (
    r.en && !event_hit |=> r.en)
    else $error("enable dropped without event");

  a_reset_on_expire: assert property (
    r.en && r.rst_mode && tick && !r.pend && r.cnt == '0
      |=> chip_reset ##1 !chip_reset)
    else $error("no one-cycle reset pulse on expiry");

  a_bad_key_event: assert property (
    s_key_fault |=> (r.rst_mode ? chip_reset : r.tmo) && !r.en)
    else $error("wrong key did not trigger event");

  a_wdrst_flag: assert property (
    chip_reset |-> r.wdrst)
    else $error("reset cause flag not set");

  a_count_on_tick: assert property (
    !tick && !event_hit |=> $stable(r.cnt))
    else $error("counter moved without tick");

  a_min_period: assert property (
    r.tc >= TC_MIN)
    else $error("period below minimum");

  a_feed_reload: assert property (
    tick && r.pend && !event_hit |=> r.cnt == $past(r.tc) && !r.pend)
    else $error("feed did not reload counter");

  a_window_guard: assert property (
    good_feed && r.en && r.cnt > r.window |=> !r.en && !r.pend)
    else $error("early feed accepted");

  a_warn_flag: assert property (
    tick && r.en && !r.pend && r.cnt == r.warn_val |=> r.warn)
    else $error("warning flag missing");

  a_wake_path: assert property (
    irq && r.wake_en |-> wake_req)
    else $error("wake request missing");

  a_bus_answer: assert property (
    s_request |=> !av_waitrequest ##1 av_waitrequest)
    else $error("bus answer not one cycle");
endmodule // wst_windowed_supervisor_timer

// >>> testbench/wst_windowed_supervisor_timer_tb_top.sv
// Self-checking bench for the windowed supervisor timer.
// Assumes the design answers each register access with one waitrequest-low
// cycle and that supervisor_clock may run at one eighth of clk.
module wst_windowed_supervisor_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wst_pkg::*;

  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 por_rst = 1'b1;
  logic                 supervisor_clock = 1'b0;
  logic [1:0]           sup_div = 2'h0;
  wst_av_req_type       av_req = '0;
  logic [DATA_W-1:0]    av_readdata;
  logic                 av_waitrequest;
  logic                 chip_reset;
  logic                 irq;
  logic                 wake_req;
  logic [DATA_W-1:0]    q;
  int                   bad_count = 0;
  int                   comparisons = 0;
  int                   n;

  wst_windowed_supervisor_timer DUT (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .por_rst          (por_rst),
    .supervisor_clock (supervisor_clock),
    .av_req           (av_req),
    .av_readdata      (av_readdata),
    .av_waitrequest   (av_waitrequest),
    .chip_reset       (chip_reset),
    .irq              (irq),
    .wake_req         (wake_req)
  );

  always #2 clk = ~clk;

  // Supervisor clock at one eighth of clk, one tick every 32 clk
  always @(posedge clk) begin
    sup_div <= sup_div + 2'h1;
    if (sup_div == 2'h3) begin
      supervisor_clock <= ~supervisor_clock;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    av_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    do begin
      @(posedge clk);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req <= '0;
  endtask

  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, q, exp);
  endtask

  task automatic feed();
    bus(1'b1, OFS_FEED, 32'h000000AA);
    bus(1'b1, OFS_FEED, 32'h00000055);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    chk("irq", {31'h0, irq}, 32'h1);
  endtask

  task automatic close_out();
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    rd_chk("mode", OFS_MODE, 32'h0);
    rd_chk("timeout", OFS_TIMEOUT, 32'h00FFFFFF);
    rd_chk("warn", OFS_WARN, 32'h0);
    rd_chk("window", OFS_WINDOW, 32'h00FFFFFF);
    rd_chk("feedreg", OFS_FEED, 32'h0);
    rd_chk("status", OFS_STATUS, 32'h0);
    rd_chk("unmapped", 5'h1C, 32'h0);
    bus(1'b1, OFS_TIMEOUT, 32'h00000010);
    rd_chk("tc_floor", OFS_TIMEOUT, 32'h000000FF);
    // Warning, wake and lock of the enable
    bus(1'b1, OFS_WARN, 32'h00000080);
    bus(1'b1, OFS_MODE, 32'h00000031);
    feed();
    bus(1'b1, OFS_MODE, 32'h00000030);
    rd_chk("en_lock", OFS_MODE, 32'h00000031);
    wait_irq();
    @(posedge clk);
    chk("wake", {31'h0, wake_req}, 32'h1);
    rd_chk("warn_flag", OFS_MODE, 32'h00000039);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count_dn", {31'h0, q <= 32'h80}, 32'h1);
    bus(1'b1, OFS_MODE, 32'h00000038);
    repeat (3) @(posedge clk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    // Feed too early in the window
    bus(1'b1, OFS_WINDOW, 32'h00000040);
    feed();
    wait_irq();
    rd_chk("win_fault", OFS_MODE, 32'h00000034);
    rd_chk("reload", OFS_COUNT, 32'h000000FF);
    bus(1'b1, OFS_MODE, 32'h00000004);
    repeat (3) @(posedge clk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    // Broken feed sequence
    bus(1'b1, OFS_WINDOW, 32'h00FFFFFF);
    bus(1'b1, OFS_MODE, 32'h00000001);
    bus(1'b1, OFS_FEED, 32'h000000AA);
    rd_chk("armed", OFS_STATUS, 32'h00000002);
    wait_irq();
    chk("wake_off", {31'h0, wake_req}, 32'h0);
    rd_chk("bad_feed", OFS_MODE, 32'h00000004);
    bus(1'b1, OFS_MODE, 32'h00000004);
    // Wrong first key while enabled
    bus(1'b1, OFS_MODE, 32'h00000001);
    bus(1'b1, OFS_FEED, 32'h00000012);
    rd_chk("bad_key", OFS_MODE, 32'h00000004);
    bus(1'b1, OFS_MODE, 32'h00000004);
    // Expiry in reset mode, period of TIMEOUT+1 ticks
    bus(1'b1, OFS_MODE, 32'h00000003);
    feed();
    n = 0;
    while (chip_reset !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk("period", {31'h0, n >= 8190 && n <= 8240}, 32'h1);
    rd_chk("cause", OFS_STATUS, 32'h00000001);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    chk("rst_pulse", {31'h0, chip_reset}, 32'h0);
    rd_chk("cause_kept", OFS_STATUS, 32'h00000001);
    rd_chk("mode_hw", OFS_MODE, 32'h0);
    bus(1'b1, OFS_STATUS, 32'h00000001);
    rd_chk("cause_clr", OFS_STATUS, 32'h0);
    close_out();
  end
endmodule // wst_windowed_supervisor_timer_tb_top
